// ==== src/slltc_defs.vh ====
`ifndef SLLTC_DEFS_VH
`define SLLTC_DEFS_VH

// Register addresses
`define SLLTC_A_EXIT_NS        16'h4829
`define SLLTC_A_DZERO_UI       16'h482a
`define SLLTC_A_DTRAIL_UI      16'h482b
`define SLLTC_A_CZERO_UI       16'h482c
`define SLLTC_A_CPREP_UI       16'h482d
`define SLLTC_A_CPOST_UI       16'h482e
`define SLLTC_A_CTRAIL_UI      16'h482f
`define SLLTC_A_LPX_UI         16'h4830
`define SLLTC_A_DPREP_UI       16'h4831
`define SLLTC_A_EXIT_UI        16'h4832
`define SLLTC_A_LOWB_HI        16'h4833
`define SLLTC_A_LOWB_LO        16'h4834
`define SLLTC_A_TOPB_HI        16'h4835
`define SLLTC_A_TOPB_LO        16'h4836
`define SLLTC_A_PERIOD         16'h4837
`define SLLTC_A_WAKEUP         16'h4838
`define SLLTC_A_DIRDLY         16'h483a
`define SLLTC_A_LPGPIO         16'h483b
`define SLLTC_A_LPXPRE         16'h483c
`define SLLTC_A_TA_GO          16'h483d
`define SLLTC_A_TA_SURE        16'h483e
`define SLLTC_A_TA_GET         16'h483f
`define SLLTC_A_CEIL_HI        16'h4846
`define SLLTC_A_CEIL_LO        16'h4847
`define SLLTC_A_FLOOR_HI       16'h4848
`define SLLTC_A_FLOOR_LO       16'h4849
`define SLLTC_A_IRQ            16'h4850
`define SLLTC_A_TXWR           16'h4851
`define SLLTC_A_TXSTOP         16'h4852
`define SLLTC_A_TAACK          16'h4853
`define SLLTC_A_TAREQ          16'h4854
`define SLLTC_A_HS0            16'h4861
`define SLLTC_A_HS3            16'h4864
`define SLLTC_A_STATUS         16'h4865

// Reset values
`define SLLTC_R_EXIT_NS        8'h64
`define SLLTC_R_DZERO_UI       8'h05
`define SLLTC_R_DTRAIL_UI      8'h04
`define SLLTC_R_CPOST_UI       8'h34
`define SLLTC_R_DPREP_UI       8'h04
`define SLLTC_R_ZERO           8'h00
`define SLLTC_R_ONES           8'hff
`define SLLTC_R_PERIOD         8'h19
`define SLLTC_R_WAKEUP         8'h02
`define SLLTC_R_DIRDLY         8'h08
`define SLLTC_R_LPGPIO         8'h33
`define SLLTC_R_LPXPRE         8'h4f
`define SLLTC_R_TA_GO          8'h10
`define SLLTC_R_TA_SURE        8'h06
`define SLLTC_R_TA_GET         8'h14
`define SLLTC_R_CLIP_HI        8'h0f

// Field positions
`define SLLTC_F_L1_SEL         7
`define SLLTC_F_L1_DIR         6
`define SLLTC_F_L1_P           5
`define SLLTC_F_L1_N           4
`define SLLTC_F_L2_SEL         3
`define SLLTC_F_L2_DIR         2
`define SLLTC_F_L2_P           1
`define SLLTC_F_L2_N           0
`define SLLTC_F_EXIT_SEL       3
`define SLLTC_WAKE_SHIFT       12
`define SLLTC_DIR_SHIFT        1

`endif

// ==== src/slltc_top.v ====
// Functional notes
// RQ1: Exit time is ns minimum plus UI count.
// RQ2: Separate UI minimums added to ns minimums. Code adds them to a zero ns minimum for every interval but exit.
// RQ3: Prepare intervals bounded by min and max.
// RQ4: Lane register access limited to address window.
// RQ5: Auto calculations use period with fraction bit.
// RQ6: Hold wakeup state for value times 4096.
// RQ7: Wait direction delay times two after LP11.
// RQ8: Per-lane auto/manual direction and manual levels.
// RQ9: Pulse width in SCLK, preclock in double pixel clock.
// RQ10: Turnaround go, sure, get SCLK counts.
// RQ11: Clip output data to programmed maximum.
// RQ12: Clip output data to programmed minimum.
// RQ13: Irq register write gives one-cycle pulse.
// RQ14: Transmit-write pulse sends byte in escape.
// RQ15: Transmit-stop pulse returns lane to LP11.
// RQ16: Accept write prepares for turnaround reception.
// RQ17: Request write sends turnaround to far end.
// RQ18: Four handshake bytes readable, never writable.
// RQ19: Status flags receiver active and transmitter busy.
// RQ20: Status low bits show live lane levels.
// RQ21: Selector chooses auto or programmed value.
// RQ22: Pulse registers store nothing; reads return zero. Code keeps the last transmit-write byte on esc_byte.
// RQ23: Software requests turnaround only when idle.
`timescale 1ns/10ps
`default_nettype none
`include "slltc_defs.vh"

module slltc_top #(
  parameter DATA_W = 12,
  parameter UI_NS_X2 = 4
)(
  // Clock and reset
  input  wire                ref_clk,
  input  wire                rst_b,
  // Register port
  input  wire                reg_wr,
  input  wire                reg_rd,
  input  wire [15:0]         reg_addr,
  input  wire [7:0]          reg_wdata,
  output reg  [7:0]          reg_rdata,
  // Lane-side access requests
  input  wire                lane_acc_req,
  input  wire [15:0]         lane_acc_addr,
  output reg                 lane_acc_grant,
  // Timing selectors and lane events
  input  wire [7:0]          timing_source_select,
  input  wire                lane_at_lp11,
  input  wire                wake_start,
  input  wire                lane1_auto_direction,
  input  wire                lane2_auto_direction,
  // Handshake bytes and status inputs
  input  wire [31:0]         handshake_in,
  input  wire                lp_receive_active,
  input  wire                tx_busy,
  input  wire                lane1_p_level_in,
  input  wire                lane1_n_level_in,
  input  wire                lane2_p_level_in,
  input  wire                lane2_n_level_in,
  // Pixel data path
  input  wire [DATA_W-1:0]   pix_in,
  output reg  [DATA_W-1:0]   pix_out,
  // Computed intervals in half-ns units; SCLK, pixel-clock and cycle counts
  output reg  [9:0]          exit_interval,
  output reg  [9:0]          data_zero_interval,
  output reg  [9:0]          data_trail_interval,
  output reg  [9:0]          clock_zero_interval,
  output reg  [9:0]          clock_post_interval,
  output reg  [9:0]          clock_trail_interval,
  output reg  [9:0]          lp_pulse_interval,
  output reg  [9:0]          data_prep_interval,
  output reg  [9:0]          clock_prep_interval,
  output reg  [3:0]          lp_pulse_sclk,
  output reg  [3:0]          clock_pre_pclk,
  output reg  [7:0]          ta_go_cycles,
  output reg  [7:0]          ta_sure_cycles,
  output reg  [7:0]          ta_get_cycles,
  // Lane control
  output reg                 wake_hold,
  output reg                 lane1_dir,
  output reg                 lane2_dir,
  output reg                 lane1_p_level_out,
  output reg                 lane1_n_level_out,
  output reg                 lane2_p_level_out,
  output reg                 lane2_n_level_out,
  // Pulses
  output reg                 mcu_irq,
  output reg                 esc_send,
  output reg  [7:0]          esc_byte,
  output reg                 esc_stop,
  output reg                 ta_accept,
  output reg                 ta_request
);

  reg [7:0] exit_ns, dzero_ui, dtrail_ui, czero_ui, cprep_ui, cpost_ui;
  reg [7:0] ctrail_ui, lpx_ui, dprep_ui, exit_ui;
  reg [7:0] lowb_hi, lowb_lo, topb_hi, topb_lo, period, wakeup, dirdly;
  reg [7:0] lp_gpio, lpxpre, ta_go, ta_sure, ta_get;
  reg [7:0] ceil_hi, ceil_lo, floor_hi, floor_lo;
  reg [7:0] next_rdata;

  reg [20:0] wake_cnt;
  reg [8:0]  dir_cnt;
  reg        dir_pending;

  wire [15:0] ceil_v  = {ceil_hi, ceil_lo};
  wire [15:0] floor_v = {floor_hi, floor_lo};

  // Interval in half-ns: ns minimum plus UI count times UI period, or period times 4 when sel is 0
  function [9:0] ival;
    input [7:0] ns_min;
    input [7:0] ui;
    input       sel;
    input [7:0] per;
    reg   [15:0] t;
    begin
      t = {7'h00, ns_min, 1'b0} + {8'h00, ui} * UI_NS_X2[15:0];
      if (!sel)
        t = {8'h00, per} * 16'h0004;
      ival = t[9:0];
    end
  endfunction

  // Clamp a prepare UI count into its min/max range
  // A zero ceiling leaves the range open above
  function [7:0] clamp_ui;
    input [7:0] v;
    input [3:0] lo;
    input [3:0] hi;
    begin
      clamp_ui = v;
      if (v < {4'h0, lo})
        clamp_ui = {4'h0, lo};
      else if (hi != 4'h0 && v > {4'h0, hi})
        clamp_ui = {4'h0, hi};
    end
  endfunction

  // Register writes
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exit_ns <= `SLLTC_R_EXIT_NS;
      dzero_ui <= `SLLTC_R_DZERO_UI;
      dtrail_ui <= `SLLTC_R_DTRAIL_UI;
      czero_ui <= `SLLTC_R_ZERO;
      cprep_ui <= `SLLTC_R_ZERO;
      cpost_ui <= `SLLTC_R_CPOST_UI;
      ctrail_ui <= `SLLTC_R_ZERO;
      lpx_ui <= `SLLTC_R_ZERO;
      dprep_ui <= `SLLTC_R_DPREP_UI;
      exit_ui <= `SLLTC_R_ZERO;
      lowb_hi <= `SLLTC_R_ZERO;
      lowb_lo <= `SLLTC_R_ZERO;
      topb_hi <= `SLLTC_R_ONES;
      topb_lo <= `SLLTC_R_ONES;
      period <= `SLLTC_R_PERIOD;
      wakeup <= `SLLTC_R_WAKEUP;
      dirdly <= `SLLTC_R_DIRDLY;
      lp_gpio <= `SLLTC_R_LPGPIO;
      lpxpre <= `SLLTC_R_LPXPRE;
      ta_go <= `SLLTC_R_TA_GO;
      ta_sure <= `SLLTC_R_TA_SURE;
      ta_get <= `SLLTC_R_TA_GET;
      ceil_hi <= `SLLTC_R_CLIP_HI;
      ceil_lo <= `SLLTC_R_ONES;
      floor_hi <= `SLLTC_R_CLIP_HI;
      floor_lo <= `SLLTC_R_ONES;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SLLTC_A_EXIT_NS:   exit_ns <= reg_wdata;
        `SLLTC_A_DZERO_UI:  dzero_ui <= reg_wdata;
        `SLLTC_A_DTRAIL_UI: dtrail_ui <= reg_wdata;
        `SLLTC_A_CZERO_UI:  czero_ui <= reg_wdata;
        `SLLTC_A_CPREP_UI:  cprep_ui <= reg_wdata;
        `SLLTC_A_CPOST_UI:  cpost_ui <= reg_wdata;
        `SLLTC_A_CTRAIL_UI: ctrail_ui <= reg_wdata;
        `SLLTC_A_LPX_UI:    lpx_ui <= reg_wdata;
        `SLLTC_A_DPREP_UI:  dprep_ui <= reg_wdata;
        `SLLTC_A_EXIT_UI:   exit_ui <= reg_wdata;
        `SLLTC_A_LOWB_HI:   lowb_hi <= reg_wdata;
        `SLLTC_A_LOWB_LO:   lowb_lo <= reg_wdata;
        `SLLTC_A_TOPB_HI:   topb_hi <= reg_wdata;
        `SLLTC_A_TOPB_LO:   topb_lo <= reg_wdata;
        `SLLTC_A_PERIOD:    period <= reg_wdata;
        `SLLTC_A_WAKEUP:    wakeup <= reg_wdata;
        `SLLTC_A_DIRDLY:    dirdly <= reg_wdata;
        `SLLTC_A_LPGPIO:    lp_gpio <= reg_wdata;
        `SLLTC_A_LPXPRE:    lpxpre <= reg_wdata;
        `SLLTC_A_TA_GO:     ta_go <= reg_wdata;
        `SLLTC_A_TA_SURE:   ta_sure <= reg_wdata;
        `SLLTC_A_TA_GET:    ta_get <= reg_wdata;
        `SLLTC_A_CEIL_HI:   ceil_hi <= {4'h0, reg_wdata[3:0]};
        `SLLTC_A_CEIL_LO:   ceil_lo <= reg_wdata;
        `SLLTC_A_FLOOR_HI:  floor_hi <= {4'h0, reg_wdata[3:0]};
        `SLLTC_A_FLOOR_LO:  floor_lo <= reg_wdata;
        default:            ;
      endcase
    end
  end

  // Read mux; pulse registers and unmapped read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `SLLTC_A_EXIT_NS:   next_rdata = exit_ns;
      `SLLTC_A_DZERO_UI:  next_rdata = dzero_ui;
      `SLLTC_A_DTRAIL_UI: next_rdata = dtrail_ui;
      `SLLTC_A_CZERO_UI:  next_rdata = czero_ui;
      `SLLTC_A_CPREP_UI:  next_rdata = {2'b00, cprep_ui[5:0]};
      `SLLTC_A_CPOST_UI:  next_rdata = cpost_ui;
      `SLLTC_A_CTRAIL_UI: next_rdata = ctrail_ui;
      `SLLTC_A_LPX_UI:    next_rdata = lpx_ui;
      `SLLTC_A_DPREP_UI:  next_rdata = dprep_ui;
      `SLLTC_A_EXIT_UI:   next_rdata = exit_ui;
      `SLLTC_A_LOWB_HI:   next_rdata = lowb_hi;
      `SLLTC_A_LOWB_LO:   next_rdata = lowb_lo;
      `SLLTC_A_TOPB_HI:   next_rdata = topb_hi;
      `SLLTC_A_TOPB_LO:   next_rdata = topb_lo;
      `SLLTC_A_PERIOD:    next_rdata = period;
      `SLLTC_A_WAKEUP:    next_rdata = wakeup;
      `SLLTC_A_DIRDLY:    next_rdata = dirdly;
      `SLLTC_A_LPGPIO:    next_rdata = lp_gpio;
      `SLLTC_A_LPXPRE:    next_rdata = lpxpre;
      `SLLTC_A_TA_GO:     next_rdata = ta_go;
      `SLLTC_A_TA_SURE:   next_rdata = ta_sure;
      `SLLTC_A_TA_GET:    next_rdata = ta_get;
      `SLLTC_A_CEIL_HI:   next_rdata = ceil_hi;
      `SLLTC_A_CEIL_LO:   next_rdata = ceil_lo;
      `SLLTC_A_FLOOR_HI:  next_rdata = floor_hi;
      `SLLTC_A_FLOOR_LO:  next_rdata = floor_lo;

      `SLLTC_A_STATUS:                                                   // [RQ19] [RQ20]
        next_rdata = {2'b00, lp_receive_active, tx_busy, lane1_p_level_in,
                      lane1_n_level_in, lane2_p_level_in, lane2_n_level_in};
      default:
        if (reg_addr >= `SLLTC_A_HS0 && reg_addr <= `SLLTC_A_HS3)   // [RQ18]
          next_rdata = handshake_in[{reg_addr[1:0] - 2'd1, 3'b000} +: 8];
    endcase
  end

  // Registered outputs and pulses
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 8'h00;
      lane_acc_grant <= 1'b0;
      pix_out <= {DATA_W{1'b0}};
      exit_interval <= 10'h000;
      data_zero_interval <= 10'h000;
      data_trail_interval <= 10'h000;
      clock_zero_interval <= 10'h000;
      clock_post_interval <= 10'h000;
      clock_trail_interval <= 10'h000;
      lp_pulse_interval <= 10'h000;
      data_prep_interval <= 10'h000;
      clock_prep_interval <= 10'h000;
      lp_pulse_sclk <= 4'h0;
      clock_pre_pclk <= 4'h0;
      ta_go_cycles <= 8'h00;
      ta_sure_cycles <= 8'h00;
      ta_get_cycles <= 8'h00;
      lane1_p_level_out <= 1'b0;
      lane1_n_level_out <= 1'b0;
      lane2_p_level_out <= 1'b0;
      lane2_n_level_out <= 1'b0;
      mcu_irq <= 1'b0;
      esc_send <= 1'b0;
      esc_byte <= 8'h00;
      esc_stop <= 1'b0;
      ta_accept <= 1'b0;
      ta_request <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;

      lane_acc_grant <= lane_acc_req && lane_acc_addr >= {lowb_hi, lowb_lo}   // [RQ4]
                        && lane_acc_addr <= {topb_hi, topb_lo};
      if ({4'h0, pix_in} > ceil_v)                                  // [RQ11]
        pix_out <= ceil_v[DATA_W-1:0];
      else if ({4'h0, pix_in} < floor_v)                            // [RQ12]
        pix_out <= floor_v[DATA_W-1:0];
      else
        pix_out <= pix_in;

      // Timing intervals; selector 0 derives from period [RQ5] [RQ21]
      exit_interval <= ival(exit_ns, exit_ui, timing_source_select[`SLLTC_F_EXIT_SEL],
                            period);                                // [RQ1]
      data_zero_interval <= ival(8'h00, dzero_ui, timing_source_select[2], period); // [RQ2]
      data_trail_interval <= ival(8'h00, dtrail_ui, timing_source_select[1], period);
      clock_zero_interval <= ival(8'h00, czero_ui, timing_source_select[0], period);
      clock_post_interval <= ival(8'h00, cpost_ui, timing_source_select[5], period);
      clock_trail_interval <= ival(8'h00, ctrail_ui, timing_source_select[4], period);
      lp_pulse_interval <= ival(8'h00, lpx_ui, 1'b1, period);
      data_prep_interval <= ival(8'h00, clamp_ui(dprep_ui, dprep_ui[3:0],
                                 dprep_ui[7:4]), timing_source_select[7], period); // [RQ3]
      clock_prep_interval <= ival(8'h00, clamp_ui(cprep_ui, cprep_ui[3:0],
                                  {2'b00, cprep_ui[5:4]}), timing_source_select[6], period);
      lp_pulse_sclk <= lpxpre[7:4];                                 // [RQ9]
      clock_pre_pclk <= lpxpre[3:0];

      ta_go_cycles <= ta_go;                                        // [RQ10]
      ta_sure_cycles <= ta_sure;
      ta_get_cycles <= ta_get;

      lane1_p_level_out <= lp_gpio[`SLLTC_F_L1_P];                  // [RQ8]
      lane1_n_level_out <= lp_gpio[`SLLTC_F_L1_N];
      lane2_p_level_out <= lp_gpio[`SLLTC_F_L2_P];
      lane2_n_level_out <= lp_gpio[`SLLTC_F_L2_N];

      // Write-only pulse registers read as zero; only the transmit-write byte is kept, on esc_byte [RQ22]
      mcu_irq <= reg_wr && reg_addr == `SLLTC_A_IRQ;                // [RQ13]
      esc_send <= reg_wr && reg_addr == `SLLTC_A_TXWR;              // [RQ14]
      if (reg_wr && reg_addr == `SLLTC_A_TXWR)
        esc_byte <= reg_wdata;
      esc_stop <= reg_wr && reg_addr == `SLLTC_A_TXSTOP;            // [RQ15]
      ta_accept <= reg_wr && reg_addr == `SLLTC_A_TAACK;            // [RQ16]
      ta_request <= reg_wr && reg_addr == `SLLTC_A_TAREQ;           // [RQ17]
    end
  end

  // Wakeup hold and direction-change delay
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_cnt <= 21'h000000;
      wake_hold <= 1'b0;
      dir_cnt <= 9'h000;
      dir_pending <= 1'b0;
      lane1_dir <= 1'b0;
      lane2_dir <= 1'b0;
    end
    else
    begin
      if (wake_start && !wake_hold)
      begin
        wake_cnt <= {1'b0, wakeup, 12'h000};                        // [RQ6]
        wake_hold <= wakeup != 8'h00;
      end
      else if (wake_hold)
      begin
        wake_cnt <= wake_cnt - 21'h000001;
        wake_hold <= wake_cnt > 21'h000001;
      end

      // Direction waits for the lane to rest at LP11
      if (!lane_at_lp11)
      begin
        dir_cnt <= {dirdly, 1'b0};                                  // [RQ7]
        dir_pending <= 1'b1;
      end
      else if (dir_pending && dir_cnt != 9'h000)
        dir_cnt <= dir_cnt - 9'h001;
      else
      begin
        dir_pending <= 1'b0;
        lane1_dir <= lp_gpio[`SLLTC_F_L1_SEL] ? lp_gpio[`SLLTC_F_L1_DIR]  // [RQ8]
                                              : lane1_auto_direction;
        lane2_dir <= lp_gpio[`SLLTC_F_L2_SEL] ? lp_gpio[`SLLTC_F_L2_DIR]
                                              : lane2_auto_direction;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/slltc_chk_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "slltc_defs.vh"
module slltc_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Status inputs
  input wire logic        lp_receive_active,
  input wire logic        tx_busy,
  input wire logic        lane1_p_level_in,
  input wire logic        lane1_n_level_in,
  input wire logic        lane2_p_level_in,
  input wire logic        lane2_n_level_in,
  // Pulses and counts
  input wire logic        mcu_irq,
  input wire logic        esc_send,
  input wire logic [7:0]  esc_byte,
  input wire logic        esc_stop,
  input wire logic        ta_accept,
  input wire logic        ta_request,
  input wire logic [7:0]  ta_go_cycles
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_irq_pulse:
    assert property (mcu_irq == $past(reg_wr && reg_addr == `SLLTC_A_IRQ))
    else $error("irq pulse mismatch");
  a_escape_byte:
    assert property (reg_wr && reg_addr == `SLLTC_A_TXWR
      |=> esc_send && esc_byte == $past(reg_wdata))
    else $error("escape byte not sent");
  a_stop_source:
    assert property (esc_stop |-> $past(reg_wr && reg_addr == `SLLTC_A_TXSTOP))
    else $error("stray stop pulse");
  a_accept_pulse:
    assert property (reg_wr && reg_addr == `SLLTC_A_TAACK |=> ta_accept)
    else $error("accept pulse missing");
  a_request_cause:
    assert property ($rose(ta_request) |-> $past(reg_wr && reg_addr == `SLLTC_A_TAREQ))
    else $error("stray turnaround request");
  a_status_view:
    assert property (reg_rd && reg_addr == `SLLTC_A_STATUS |=> reg_rdata == {2'b00,
      $past(lp_receive_active), $past(tx_busy), $past(lane1_p_level_in),
      $past(lane1_n_level_in), $past(lane2_p_level_in), $past(lane2_n_level_in)})
    else $error("status read mismatch");
  a_pulse_reads:
    assert property (reg_rd && reg_addr >= `SLLTC_A_IRQ && reg_addr <= `SLLTC_A_TAREQ
      |=> reg_rdata == 8'h00)
    else $error("pulse register read not zero");
  a_ta_go_count:
    assert property (reg_wr && reg_addr == `SLLTC_A_TA_GO
      |-> ##2 ta_go_cycles == $past(reg_wdata, 2))
    else $error("go count not updated");
endmodule

bind slltc_top slltc_chk i_slltc_chk (
  .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .lp_receive_active, .tx_busy, .lane1_p_level_in, .lane1_n_level_in,
  .lane2_p_level_in, .lane2_n_level_in, .mcu_irq, .esc_send, .esc_byte,
  .esc_stop, .ta_accept, .ta_request, .ta_go_cycles
);
`default_nettype wire

// ==== verification/slltc_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module slltc_far_end #(
  parameter int BUSY_CYC = 24,
  parameter int TALK_CYC = 16
)(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Device side
  input  wire logic esc_send,
  input  wire logic ta_request,
  input  wire logic lane1_dir,
  input  wire logic lane1_p_level_out,
  input  wire logic lane1_n_level_out,
  // Toward the device
  output logic      tx_busy,
  output logic      lp_receive_active,
  output logic      lane1_p_level_in,
  output logic      lane1_n_level_in
);
  int   busy_left;
  int   talk_left;
  logic flip;

  always @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      busy_left <= 0;
      talk_left <= 0;
      flip <= 1'b0;
    end
    else
    begin
      flip <= ~flip;
      // Escape byte keeps the line occupied for a while
      busy_left <= esc_send ? BUSY_CYC : (busy_left > 0 ? busy_left - 1 : 0);
      // New lane owner answers after a short pause
      talk_left <= ta_request ? TALK_CYC + 4 : (talk_left > 0 ? talk_left - 1 : 0);
    end
  assign tx_busy = busy_left > 0;
  assign lp_receive_active = talk_left > 0 && talk_left <= TALK_CYC;
  // Released line rests at LP11; while answering, levels change every cycle
  assign lane1_p_level_in = lane1_dir ? lane1_p_level_out : (lp_receive_active ? flip : 1'b1);
  assign lane1_n_level_in = lane1_dir ? lane1_n_level_out : (lp_receive_active ? ~flip : 1'b1);
endmodule
`default_nettype wire

// ==== verification/slltc_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "slltc_defs.vh"
module slltc_top_test;
  localparam int UI = 4;
  logic        ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        lane_acc_req = 1'b0, lane_at_lp11 = 1'b0, wake_start = 1'b0;
  logic        lane1_auto_direction = 1'b0, lane2_auto_direction = 1'b0;
  logic        lane2_p_level_in = 1'b1, lane2_n_level_in = 1'b1;
  logic [15:0] reg_addr = 16'h0000, lane_acc_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, timing_source_select = 8'h00, d;
  logic [31:0] handshake_in = 32'hc3a5_5a3c;
  logic [11:0] pix_in = 12'h000;
  wire  [7:0]  reg_rdata, esc_byte;
  wire  [11:0] pix_out;
  wire  [9:0]  exit_interval, data_zero_interval;
  wire         lane_acc_grant, tx_busy, lp_receive_active, lane1_p_level_in, lane1_n_level_in;
  wire         wake_hold, lane1_dir, lane2_dir, lane1_p_level_out, lane1_n_level_out;
  wire         lane2_p_level_out, lane2_n_level_out, mcu_irq, esc_send, esc_stop;
  wire         ta_accept, ta_request;
  int          fails = 0, total_checks = 0, cyc = 0;
  logic [23:0] rv [26] = '{24'h482964, 24'h482a05, 24'h482b04, 24'h482c00, 24'h482d00,
    24'h482e34, 24'h482f00, 24'h483000, 24'h483104, 24'h483200, 24'h483300, 24'h483400,
    24'h4835ff, 24'h4836ff, 24'h483719, 24'h483802, 24'h483a08, 24'h483b33, 24'h483c4f,
    24'h483d10, 24'h483e06, 24'h483f14, 24'h48460f, 24'h4847ff, 24'h48480f, 24'h4849ff};

  slltc_top #(.DATA_W(12), .UI_NS_X2(UI)) i_slltc_top (
    .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .lane_acc_req, .lane_acc_addr, .lane_acc_grant, .timing_source_select, .lane_at_lp11,
    .wake_start, .lane1_auto_direction, .lane2_auto_direction, .handshake_in,
    .lp_receive_active, .tx_busy, .lane1_p_level_in, .lane1_n_level_in, .lane2_p_level_in,
    .lane2_n_level_in, .pix_in, .pix_out, .exit_interval, .data_zero_interval,
    .data_trail_interval(), .clock_zero_interval(), .clock_post_interval(),
    .clock_trail_interval(), .lp_pulse_interval(), .data_prep_interval(),
    .clock_prep_interval(), .lp_pulse_sclk(), .clock_pre_pclk(), .ta_go_cycles(),
    .ta_sure_cycles(), .ta_get_cycles(), .wake_hold, .lane1_dir, .lane2_dir,
    .lane1_p_level_out, .lane1_n_level_out, .lane2_p_level_out, .lane2_n_level_out,
    .mcu_irq, .esc_send, .esc_byte, .esc_stop, .ta_accept, .ta_request
  );
  slltc_far_end i_slltc_far_end (
    .ref_clk, .rst_b, .esc_send, .ta_request, .lane1_dir, .lane1_p_level_out,
    .lane1_n_level_out, .tx_busy, .lp_receive_active, .lane1_p_level_in, .lane1_n_level_in
  );

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  // Software polls the busy flag before the next escape command
  task automatic wait_idle();
    for (int n = 0; n < 100; n++)
    begin
      rd(`SLLTC_A_STATUS);
      if (d[4] === 1'b0)
        return;
    end
    chk("busy clears", d[4], 1'b0);
  endtask

  task automatic t_regs();
    logic [7:0] m;
    for (int i = 0; i < 26; i++)
    begin
      m = (rv[i][15:8] == 8'h46 || rv[i][15:8] == 8'h48) ? 8'h0f : 8'hff;
      m = (rv[i][15:8] == 8'h2d) ? 8'h3f : m;
      rdc(rv[i][23:8], rv[i][7:0]);
      wr(rv[i][23:8], ~rv[i][7:0]);
      rdc(rv[i][23:8], ~rv[i][7:0] & m);
      wr(rv[i][23:8], rv[i][7:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h4861 + 16'(i), 8'h00);
      rdc(16'h4861 + 16'(i), handshake_in[8*i +: 8]);
    end
    for (int i = 0; i < 5; i++)
      rdc(16'h4850 + 16'(i), 8'h00);
    rdc(16'h4839, 8'h00);
  endtask
  task automatic t_pulses();
    lane2_p_level_in = 1'b0;
    rdc(`SLLTC_A_STATUS, 8'h0d);
    for (int i = 0; i < 5; i++)
    begin
      wait_idle();
      wr(16'h4850 + 16'(i), 8'h5a + 8'(i));
      chk("pulse", {ta_request, ta_accept, esc_stop, esc_send, mcu_irq}, 16'h1 << i);
      if (i == 1)
        chk("escape byte", esc_byte, 8'h5b);
      @(negedge ref_clk);
      chk("pulse end", {ta_request, ta_accept, esc_stop, esc_send, mcu_irq}, 16'h0);
      if (i == 1)
        rdc(`SLLTC_A_STATUS, 8'h1d);
    end
    for (int n = 0; n < 40 && d[5] !== 1'b1; n++)
      rd(`SLLTC_A_STATUS);
    chk("receiver active", d[5], 1'b1);
  endtask
  task automatic t_window();
    logic [15:0] a [4] = '{16'h0fff, 16'h1000, 16'h10ff, 16'h1100};
    wr(`SLLTC_A_LOWB_HI, 8'h10);
    wr(`SLLTC_A_TOPB_HI, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      lane_acc_req = 1'b1;
      lane_acc_addr = a[i];
      @(negedge ref_clk);
      chk("grant", lane_acc_grant, 16'(i == 1 || i == 2));
    end
    lane_acc_req = 1'b0;
  endtask
  task automatic t_clip();
    logic [11:0] v [5] = '{12'h050, 12'h100, 12'h7ff, 12'h800, 12'hfff};
    logic [11:0] e [5] = '{12'h100, 12'h100, 12'h7ff, 12'h800, 12'h800};
    wr(`SLLTC_A_CEIL_HI, 8'h08);
    wr(`SLLTC_A_CEIL_LO, 8'h00);
    wr(`SLLTC_A_FLOOR_HI, 8'h01);
    wr(`SLLTC_A_FLOOR_LO, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge ref_clk);
      pix_in = v[i];
      @(negedge ref_clk);
      chk("clip", pix_out, e[i]);
    end
  endtask
  task automatic t_timing();
    wr(`SLLTC_A_EXIT_UI, 8'h03);
    timing_source_select = 8'h0c;
    repeat (3) @(negedge ref_clk);
    chk("exit", exit_interval, 2 * `SLLTC_R_EXIT_NS + 3 * UI);
    chk("data zero", data_zero_interval, 5 * UI);
    timing_source_select = 8'h00;
    repeat (3) @(negedge ref_clk);
    chk("exit auto", exit_interval, 4 * `SLLTC_R_PERIOD);
    chk("zero auto", data_zero_interval, 4 * `SLLTC_R_PERIOD);
  endtask
  task automatic t_wake();
    int n;
    n = 0;
    wr(`SLLTC_A_WAKEUP, 8'h01);
    @(negedge ref_clk);
    wake_start = 1'b1;
    @(negedge ref_clk);
    wake_start = 1'b0;
    repeat (5000)
    begin
      n += (wake_hold === 1'b1);
      @(negedge ref_clk);
    end
    chk("wake hold", n, 1 << `SLLTC_WAKE_SHIFT);
  endtask
  task automatic t_dir();
    wr(`SLLTC_A_DIRDLY, 8'h03);
    wr(`SLLTC_A_LPGPIO, 8'hd2);
    lane2_auto_direction = 1'b1;
    @(negedge ref_clk);
    chk("levels", {lane1_p_level_out, lane1_n_level_out, lane2_p_level_out,
      lane2_n_level_out}, 4'h6);
    lane_at_lp11 = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("dir early", {lane1_dir, lane2_dir}, 2'b00);
    repeat (6) @(negedge ref_clk);
    chk("dir late", {lane1_dir, lane2_dir}, 2'b11);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    t_regs();
    t_pulses();
    t_window();
    t_clip();
    t_timing();
    t_wake();
    t_dir();
    test_done();
  end
endmodule
`default_nettype wire
